// file: hdl/twu_master.v
`timescale 1ns/1ps
`include "twu_map.vh"
module twu_master #(
	parameter DIV = `TWU_DIV_DEF
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire ctl_wr_i,
	input wire ctl_flag_i,
	input wire ctl_start_i,
	input wire ctl_stop_i,
	input wire ctl_en_i,
	input wire data_valid_i,
	output reg data_ready_o,
	input wire [7:0] data_i,
	input wire [1:0] presc_i,
	output reg flag_o,
	output reg [7:0] iface_status_reg_o,
	output reg busy_o,
	input wire scl_i,
	output reg scl_oe_o,
	input wire sda_i,
	output reg sda_oe_o
);
	localparam S_IDLE = 3'h0;
	localparam S_START = 3'h1;
	localparam S_BIT = 3'h2;
	localparam S_ACK = 3'h3;
	localparam S_STOP = 3'h4;
	localparam S_WAIT = 3'h5;
	reg [2:0] st_q;
	reg [7:0] shift_data_reg_q;
	reg [2:0] bit_q;
	reg [1:0] ph_q;
	reg [7:0] div_q;
	reg addr_q;
	reg [4:0] code_q;
	reg post_q;
	reg en_q;
	reg [1:0] scl_s_q;
	reg [1:0] sda_s_q;
	reg go_start_q;
	reg go_stop_q;
	wire tick;
	wire b_valid;
	wire [7:0] b_data;
	reg b_ready;
	wire in_ready;
	wire b_push;
	wire b_pop;
	// Byte buffer keeps a word loaded while the shifter is still busy
	twu_buf2 #(.W(8)) u_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.in_valid_i(b_push),
		.in_ready_o(in_ready),
		.in_data_i(data_i),
		.out_valid_o(b_valid),
		.out_ready_i(b_ready),
		.out_data_o(b_data)
	);
	function [7:0] mk_status;
		input [4:0] c;
		input [1:0] p;
		mk_status = {c, 1'b0, p};
	endfunction
	assign tick = (div_q == 8'h00);
	// Push only while ready shows room, so a word never enters a full buffer; a valid held over two edges pushes twice
	assign b_push = data_valid_i & data_ready_o;
	assign b_pop = b_valid & b_ready;
	always @*
	begin
		b_ready = ce_i & ctl_wr_i & ctl_flag_i & flag_o & ~ctl_start_i
			& ~ctl_stop_i & (st_q == S_WAIT);
	end
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q <= S_IDLE;
			shift_data_reg_q <= 8'h00;
			bit_q <= 3'h0;
			ph_q <= 2'h0;
			div_q <= 8'h00;
			addr_q <= 1'b0;
			code_q <= `TWU_ST_IDLE;
			post_q <= 1'b0;
			en_q <= 1'b0;
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			go_start_q <= 1'b0;
			go_stop_q <= 1'b0;
			flag_o <= 1'b0;
			iface_status_reg_o <= {`TWU_ST_IDLE, 3'h0};
			busy_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			data_ready_o <= 1'b0;
		end
		else if (ce_i)
		begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			// Ready tracks room left after this edge's push and pop
			data_ready_o <= ~((~in_ready & ~b_pop)
				| (in_ready & b_valid & b_push & ~b_pop));
			div_q <= tick ? DIV[7:0] : div_q - 8'h01;
			post_q <= 1'b0;
			// status follows flag by one cycle
			if (post_q)
				iface_status_reg_o <= mk_status(code_q, presc_i);
			else if (!flag_o)
				iface_status_reg_o <= mk_status(`TWU_ST_IDLE, presc_i);
			if (ctl_wr_i)
			begin
				en_q <= ctl_en_i;
				if (ctl_flag_i && flag_o)
				begin
					flag_o <= 1'b0;
					go_start_q <= ctl_start_i;
					go_stop_q <= ctl_stop_i & ~ctl_start_i;
				end
				else if (ctl_flag_i && st_q == S_IDLE && ctl_start_i)
					go_start_q <= 1'b1;
			end
			if (b_ready)
			begin
				// single shifter for address and data
				shift_data_reg_q <= b_data;
				addr_q <= (code_q == `TWU_ST_START)
					|| (code_q == `TWU_ST_RSTART);
				bit_q <= `TWU_BIT_LAST;
				ph_q <= 2'h0;
				st_q <= S_BIT;
			end
			// steps run only with the flag clear
			else if (tick && !flag_o && en_q)
			begin
				case (st_q)
				S_IDLE, S_WAIT:
				begin
					if (go_start_q)
					begin
						go_start_q <= 1'b0;
						ph_q <= 2'h0;
						st_q <= S_START;
					end
					else if (go_stop_q)
					begin
						go_stop_q <= 1'b0;
						ph_q <= 2'h0;
						st_q <= S_STOP;
					end
				end
				S_START:
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: begin scl_oe_o <= 1'b0; sda_oe_o <= 1'b0; end
					2'h1: sda_oe_o <= 1'b1;
					2'h2: scl_oe_o <= 1'b1;
					default:
					begin
						code_q <= (st_q == S_START && busy_o)
							? `TWU_ST_RSTART : `TWU_ST_START;
						busy_o <= 1'b1;
						flag_o <= 1'b1;
						post_q <= 1'b1;
						st_q <= S_WAIT;
					end
					endcase
				end
				S_BIT, S_ACK:
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: sda_oe_o <= (st_q == S_BIT)
						? ~shift_data_reg_q[7] : 1'b0;
					2'h1: scl_oe_o <= 1'b0;
					2'h2: if (scl_s_q[1] == 1'b0) ph_q <= ph_q;
					default:
					begin
						scl_oe_o <= 1'b1;
						if (st_q == S_BIT)
						begin
							shift_data_reg_q <= {shift_data_reg_q[6:0], 1'b0};
							bit_q <= bit_q - 3'h1;
							if (bit_q == 3'h0)
								st_q <= S_ACK;
						end
						else
						begin
							if (addr_q)
								code_q <= sda_s_q[1] ? `TWU_ST_ADDR_NACK
									: `TWU_ST_ADDR_ACK;
							else
								code_q <= sda_s_q[1] ? `TWU_ST_DATA_NACK
									: `TWU_ST_DATA_ACK;
							flag_o <= 1'b1;
							post_q <= 1'b1;
							st_q <= S_WAIT;
						end
					end
					endcase
				end
				S_STOP:
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: sda_oe_o <= 1'b1;
					2'h1: scl_oe_o <= 1'b0;
					2'h2: sda_oe_o <= 1'b0;
					default:
					begin
						busy_o <= 1'b0;
						code_q <= `TWU_ST_IDLE;
						st_q <= S_IDLE;
					end
					endcase
				end
				default: st_q <= S_IDLE;
				endcase
			end
			if (flag_o)
				scl_oe_o <= 1'b1;
		end
	end
endmodule // twu_master

// file: hdl/twu_map.vh
`ifndef TWU_MAP_VH
`define TWU_MAP_VH
`define TWU_ST_START 5'h01
`define TWU_ST_RSTART 5'h02
`define TWU_ST_ADDR_ACK 5'h03
`define TWU_ST_ADDR_NACK 5'h04
`define TWU_ST_DATA_ACK 5'h05
`define TWU_ST_DATA_NACK 5'h06
`define TWU_ST_ARB_LOST 5'h07
`define TWU_ST_IDLE 5'h1f
`define TWU_DIV_DEF 8'h05
`define TWU_BIT_LAST 3'h7
`endif

// file: hdl/twu_buf2.v
`timescale 1ns/1ps
module twu_buf2 #(
	parameter W = 8
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem_q [0:1];
	reg wp_q;
	reg rp_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready_o = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o = mem_q[rp_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
			mem_q[0] <= {W{1'b0}};
			mem_q[1] <= {W{1'b0}};
		end
		else if (ce_i)
		begin
			if (push)
			begin
				mem_q[wp_q] <= in_data_i;
				wp_q <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // twu_buf2

// file: verif/twu_monitor.sv
`timescale 1ns/1ps
module twu_monitor #(
	parameter DIV = 5
) (
	input logic clk_i,
	input logic rst_b_i,
	input logic ce_i,
	input logic ctl_wr_i,
	input logic ctl_flag_i,
	input logic ctl_start_i,
	input logic ctl_stop_i,
	input logic flag_o,
	input logic [7:0] iface_status_reg_o,
	input logic busy_o,
	input logic scl_oe_o,
	input logic sda_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire clr = ce_i && ctl_wr_i && ctl_flag_i;
	flag_clear_a: assert property (flag_o && clr |=> !flag_o)
		else $error("flag not cleared");
	flag_keep_a: assert property (flag_o && !clr |=> flag_o)
		else $error("flag dropped");
	bus_still_a: assert property
		(flag_o && $past(flag_o) |-> $stable(sda_oe_o))
		else $error("sda moved while flagged");
	scl_hold_a: assert property (flag_o ##1 flag_o |-> scl_oe_o)
		else $error("scl not held low");
	start_go_a: assert property (!flag_o && !busy_o && clr && ctl_start_i
		|-> ##[1:60] $rose(sda_oe_o) && !scl_oe_o) else $error("no start");
	byte_step_a: assert property
		(flag_o && clr && !ctl_start_i && !ctl_stop_i
		|=> !flag_o [*8] ##[1:400] $rose(flag_o)) else $error("byte step");
	stop_quiet_a: assert property
		(flag_o && clr && ctl_stop_i |=> !flag_o [*8])
		else $error("flag after stop");
	status_next_a: assert property
		($rose(flag_o) |=> iface_status_reg_o[7:3] != 5'h1f)
		else $error("status not posted");
	status_idle_a: assert property
		(!flag_o ##1 !flag_o |-> iface_status_reg_o[7:3] == 5'h1f)
		else $error("status not idle");
	cover property ($rose(flag_o));
	cover property (flag_o && clr && ctl_start_i);
	cover property (flag_o && clr && ctl_stop_i);
	cover property ($rose(busy_o));
endmodule // twu_monitor

// file: verif/twu_slave.sv
`timescale 1ns/1ps
module twu_slave (
	input wire scl_i,
	input wire sda_i,
	input wire nack_i,
	output reg sda_oe_o,
	output reg [7:0] byte_o
);
	integer n = -1;
	initial sda_oe_o = 1'h0;
	initial byte_o = 8'h00;
	// A start restarts the bit count
	always @(negedge sda_i) if (scl_i) n = -1;
	// Bits arrive MSB first
	always @(posedge scl_i) if (n >= 0 && n < 8) byte_o <= {byte_o[6:0], sda_i};
	// Ack only across the ninth clock, then let go
	always @(negedge scl_i)
	begin
		n = n + 1;
		sda_oe_o <= (n == 8) && !nack_i;
		if (n == 9) n = 0;
	end
endmodule // twu_slave

// file: verif/test_two_wire_master_tx_handshake.sv
`timescale 1ns/1ps
module test_two_wire_master_tx_handshake;
	reg clk_i = 1'h0;
	reg rst_b_i = 1'h0;
	reg ctl_wr_i = 1'h0, ctl_flag_i = 1'h0, ctl_start_i = 1'h0;
	reg ctl_stop_i = 1'h0, data_valid_i = 1'h0, nack = 1'h0, ce = 1'h1;
	reg [7:0] data_i = 8'h00;
	wire data_ready_o, flag_o, busy_o, scl_oe_o, sda_oe_o, s_oe;
	wire [7:0] iface_status_reg_o, rx;
	wire scl = !scl_oe_o;
	wire sda = !(sda_oe_o || s_oe);
	integer fails = 0, compares = 0, i;
	always #25 clk_i = !clk_i;
	twu_master #(.DIV(5)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
		.ctl_wr_i(ctl_wr_i), .ctl_flag_i(ctl_flag_i), .ctl_en_i(1'h1),
		.ctl_start_i(ctl_start_i), .ctl_stop_i(ctl_stop_i), .data_i(data_i),
		.data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
		.presc_i(2'h1), .flag_o(flag_o), .busy_o(busy_o), .scl_i(scl),
		.iface_status_reg_o(iface_status_reg_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda), .sda_oe_o(sda_oe_o));
	twu_slave slv (.scl_i(scl), .sda_i(sda), .nack_i(nack), .sda_oe_o(s_oe),
		.byte_o(rx));
	task final_report;
	begin
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task wr(input s, input p);
	begin
		@(negedge clk_i);
		{ctl_wr_i, ctl_flag_i, ctl_start_i, ctl_stop_i} = {2'h3, s, p};
		@(negedge clk_i);
		ctl_wr_i = 1'h0;
	end
	endtask
	task push(input [7:0] b);
	begin
		@(negedge clk_i);
		data_valid_i = 1'h1;
		data_i = b;
		for (i = 0; i < 50 && data_ready_o !== 1'h1; i = i + 1)
			@(negedge clk_i);
		if (i == 50) fails = fails + 1;
		if (i == 50) final_report;
		@(negedge clk_i);
		data_valid_i = 1'h0;
	end
	endtask
	task step(input s, input p, input [7:0] code);
	begin
		wr(s, p);
		for (i = 0; i < 600 && flag_o !== 1'h1; i = i + 1) @(negedge clk_i);
		if (i == 600) fails = fails + 1;
		if (i == 600) final_report;
		@(negedge clk_i);
		chk("status", iface_status_reg_o & 8'hf8, code);
		chk("scl_oe", scl_oe_o, 8'h01);
	end
	endtask
	initial
	begin
		repeat (12) @(negedge clk_i);
		rst_b_i = 1'h1;
		repeat (2) @(negedge clk_i);
		chk("idle", iface_status_reg_o & 8'hf8, 8'hf8);
		step(1'h1, 1'h0, 8'h08);
		repeat (20) @(negedge clk_i);
		chk("held", flag_o, 8'h01);
		ce = 1'h0;
		wr(1'h0, 1'h0);
		chk("frozen", flag_o, 8'h01);
		ce = 1'h1;
		push(8'ha4);
		push(8'h3c);
		repeat (3) @(negedge clk_i);
		chk("full", data_ready_o, 8'h00);
		step(1'h0, 1'h0, 8'h18);
		chk("addr", rx, 8'ha4);
		step(1'h0, 1'h0, 8'h28);
		chk("data", rx, 8'h3c);
		nack = 1'h1;
		push(8'h5a);
		step(1'h0, 1'h0, 8'h30);
		chk("data", rx, 8'h5a);
		wr(1'h0, 1'h1);
		repeat (300) @(negedge clk_i);
		chk("flag", flag_o, 8'h00);
		chk("busy", busy_o, 8'h00);
		$display("test one done");
		step(1'h1, 1'h0, 8'h08);
		push(8'h91);
		step(1'h0, 1'h0, 8'h20);
		nack = 1'h0;
		step(1'h1, 1'h0, 8'h10);
		push(8'h92);
		step(1'h0, 1'h0, 8'h18);
		chk("readdr", rx, 8'h92);
		wr(1'h0, 1'h1);
		repeat (300) @(negedge clk_i);
		chk("lines", {scl_oe_o, sda_oe_o, flag_o}, 8'h00);
		$display("test two done");
		final_report;
	end
endmodule // test_two_wire_master_tx_handshake
bind twu_master twu_monitor #(.DIV(DIV)) mon (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .ce_i(ce_i), .ctl_wr_i(ctl_wr_i),
	.ctl_flag_i(ctl_flag_i), .ctl_start_i(ctl_start_i),
	.ctl_stop_i(ctl_stop_i), .flag_o(flag_o), .busy_o(busy_o),
	.iface_status_reg_o(iface_status_reg_o), .scl_oe_o(scl_oe_o),
	.sda_oe_o(sda_oe_o));
